// file: inc/sys_clk_pkg.sv
package sys_clk_pkg;
    // Register map of the documented I/O word space
    localparam logic [15:0] PROBE_SOURCE_ADDR = 16'h1C24;
    localparam int PROBE_SOURCE_LSB = 0;
    localparam int PROBE_SOURCE_W = 4;
    localparam logic [3:0] PROBE_SOURCE_RESET = 4'hB;
    localparam int IO_DATA_W = 16;

    // Divider and multiplier field widths and ratio offsets
    localparam int REFDIV_W = 12;
    localparam int REFDIV_OFFSET = 4;
    localparam int FACTOR_W = 12;
    localparam int OUTDIV_W = 7;
    localparam int OUTDIV_OFFSET = 1;

    // Reset values of control state
    localparam logic PLL_POWER_DOWN_RESET = 1'b1;
    localparam logic PROBE_DRIVER_OFF_RESET = 1'b0;

    // Select handover waits this many falling edges of the new clock
    localparam logic [1:0] HANDOVER_SYNC_EDGES = 2'h2;

    // Lock wait
    localparam int CLK_PERIOD_PS = 5000;
    localparam int LOCK_TIME_US = 4000;
    // Worked out in 64 bits: the wait in picoseconds does not fit an int
    localparam longint LOCK_PS = longint'(LOCK_TIME_US) * 1000000;
    localparam int LOCK_CYCLES = int'((LOCK_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);

    // Debug probe source codes
    localparam logic [3:0] PROBE_HIGH = 4'h1;
    localparam logic [3:0] PROBE_LOW_A = 4'h3;
    localparam logic [3:0] PROBE_LOW_B = 4'h5;
    localparam logic [3:0] PROBE_USB_A = 4'h7;
    localparam logic [3:0] PROBE_SAR = 4'h9;
    localparam logic [3:0] PROBE_SYSTEM = 4'hB;
    localparam logic [3:0] PROBE_RESERVED = 4'hD;
    localparam logic [3:0] PROBE_USB_B = 4'hF;

    typedef enum logic [1:0] {
        MUX_BYPASS = 2'b00,
        MUX_TO_PLL = 2'b01,
        MUX_PLL = 2'b10,
        MUX_TO_BYPASS = 2'b11
    } mux_state_e;
endpackage : sys_clk_pkg

// file: inc/clk_div_if.sv
`timescale 1ns/10ps
interface clk_div_if #(parameter int W = 8);
    logic src;
    logic en;
    logic [W-1:0] ratio;
    logic out;
    modport ctrl (output src, output en, output ratio, input out);
    modport div (input src, input en, input ratio, output out);
endinterface : clk_div_if

// file: hdl/clock_divider.sv
`timescale 1ns/10ps
module clock_divider #(
    parameter int W = 8,
    parameter int OFFSET = 1
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_b,
    // Divider link
    clk_div_if.div link
);
    generate
        if (W < 1 || OFFSET < 1)
        begin : g_bad_param
            $error("clock_divider: W and OFFSET must be at least 1");
        end
    endgenerate

    logic src_prev;
    logic [W:0] cnt;
    wire logic rise = link.src & ~src_prev;
    wire logic [W:0] divisor = {1'b0, link.ratio} + (W+1)'(OFFSET);
    wire logic [W:0] half = divisor >> 1;
    wire logic wrap = (cnt >= divisor - (W+1)'(1));
    wire logic [W:0] next_cnt = wrap ? '0 : cnt + (W+1)'(1);
    wire logic passthrough = ~link.en | (divisor == (W+1)'(1));
    // Odd divisors above one give a shorter high than low phase
    wire logic next_out = passthrough ? link.src : (rise ? (next_cnt < half) : link.out);

    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            src_prev <= 1'b0;
            cnt <= '0;
            link.out <= 1'b0;
        end
        else
        begin
            src_prev <= link.src;
            if (rise)
                cnt <= next_cnt;
            link.out <= next_out;
        end
    end
endmodule : clock_divider

// file: hdl/system_clock_generator.sv
`timescale 1ns/10ps
module system_clock_generator #(
    parameter int LOCK_CYCLES = sys_clk_pkg::LOCK_CYCLES
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_b,
    // Clock sources, sampled as levels
    input wire logic i_external_clock_pin,
    input wire logic i_rtc_clock,
    input wire logic i_pll_output_clock,
    input wire logic i_usb_pll_clock,
    input wire logic i_sar_clock,
    input wire logic i_source_strap_pin,
    // Control bits
    input wire logic i_pll_path_select,
    input wire logic i_pll_power_down,
    input wire logic i_refdiv_skip,
    input wire logic [sys_clk_pkg::REFDIV_W-1:0] i_refdiv_ratio,
    input wire logic [sys_clk_pkg::FACTOR_W-1:0] i_pll_feedback_factor,
    input wire logic i_outdiv_use,
    input wire logic [sys_clk_pkg::OUTDIV_W-1:0] i_outdiv_ratio,
    input wire logic i_probe_driver_off,
    // I/O word port
    input wire logic [15:0] i_io_addr,
    input wire logic [sys_clk_pkg::IO_DATA_W-1:0] i_io_wdata,
    input wire logic i_io_we,
    input wire logic i_io_re,
    output logic [sys_clk_pkg::IO_DATA_W-1:0] o_io_rdata,
    // Analogue PLL control
    output logic o_pll_power_down,
    output logic [sys_clk_pkg::FACTOR_W-1:0] o_pll_feedback_factor,
    output logic o_pll_input_clock,
    // Status
    output logic o_strap_state_bit,
    output logic o_pll_lock_done,
    output logic o_pll_mode_active,
    // Clocks out
    output logic o_system_clock,
    output logic o_debug_clock_pin,
    output logic o_debug_clock_oe_b
);
    generate
        if (LOCK_CYCLES < 1)
        begin : g_bad_lock
            $error("system_clock_generator: LOCK_CYCLES must be at least 1");
        end
    endgenerate

    clk_div_if #(.W(sys_clk_pkg::REFDIV_W)) refdiv_link ();
    clk_div_if #(.W(sys_clk_pkg::OUTDIV_W)) outdiv_link ();

    logic strap;
    logic strap_caught;
    logic [sys_clk_pkg::PROBE_SOURCE_W-1:0] probe_source_field;
    logic [31:0] lock_cnt;
    logic en_bypass;
    logic en_pll;
    logic [1:0] sync_cnt;
    logic byp_prev;
    logic pll_prev;
    sys_clk_pkg::mux_state_e state;
    sys_clk_pkg::mux_state_e next_state;

    // Reference clock and dividers
    wire logic reference_clock = strap ? i_external_clock_pin : i_rtc_clock;
    assign refdiv_link.src = reference_clock;
    assign refdiv_link.en = ~i_refdiv_skip;
    assign refdiv_link.ratio = i_refdiv_ratio;
    assign outdiv_link.src = i_pll_output_clock;
    assign outdiv_link.en = i_outdiv_use;
    assign outdiv_link.ratio = i_outdiv_ratio;

    clock_divider #(.W(sys_clk_pkg::REFDIV_W), .OFFSET(sys_clk_pkg::REFDIV_OFFSET)) u_refdiv (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .link(refdiv_link)
    );

    clock_divider #(.W(sys_clk_pkg::OUTDIV_W), .OFFSET(sys_clk_pkg::OUTDIV_OFFSET)) u_outdiv (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .link(outdiv_link)
    );

    // Glitch-free handover between the two candidate clocks
    wire logic byp_clk = reference_clock;
    wire logic pll_clk = outdiv_link.out;
    wire logic byp_fall = byp_prev & ~byp_clk;
    wire logic pll_fall = pll_prev & ~pll_clk;
    // Failsafe: a powered-down PLL is never switched to, and is left once its clock is low
    wire logic want_pll = i_pll_path_select & ~o_pll_power_down;
    wire logic handover_synced = (sync_cnt == sys_clk_pkg::HANDOVER_SYNC_EDGES);

    always_comb
    begin
        next_state = state;
        unique case (state)
            sys_clk_pkg::MUX_BYPASS:
                if (want_pll && !byp_clk)
                    next_state = sys_clk_pkg::MUX_TO_PLL;
            sys_clk_pkg::MUX_TO_PLL:
                // Power-down or deselect mid-handover falls back to bypass
                if (!want_pll)
                    next_state = sys_clk_pkg::MUX_TO_BYPASS;
                else if (handover_synced && !pll_clk)
                    next_state = sys_clk_pkg::MUX_PLL;
            sys_clk_pkg::MUX_PLL:
                if (!want_pll && !pll_clk)
                    next_state = sys_clk_pkg::MUX_TO_BYPASS;
            sys_clk_pkg::MUX_TO_BYPASS:
                if (handover_synced && !byp_clk)
                    next_state = sys_clk_pkg::MUX_BYPASS;
        endcase
    end

    wire logic next_en_bypass = (next_state == sys_clk_pkg::MUX_BYPASS);
    wire logic next_en_pll = (next_state == sys_clk_pkg::MUX_PLL);
    wire logic new_clk_fall = (state == sys_clk_pkg::MUX_TO_PLL) ? pll_fall : byp_fall;
    wire logic in_handover = (state == sys_clk_pkg::MUX_TO_PLL) || (state == sys_clk_pkg::MUX_TO_BYPASS);
    wire logic [1:0] next_sync_cnt = (!in_handover || (next_state != state)) ? 2'h0 :
        ((new_clk_fall && !handover_synced) ? sync_cnt + 2'h1 : sync_cnt);
    // Enables only change while the gated clock is low
    wire logic next_system_clock = (byp_clk & en_bypass) | (pll_clk & en_pll);

    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            state <= sys_clk_pkg::MUX_BYPASS;
            en_bypass <= 1'b1;
            en_pll <= 1'b0;
            sync_cnt <= 2'h0;
            byp_prev <= 1'b0;
            pll_prev <= 1'b0;
            o_system_clock <= 1'b0;
            o_pll_mode_active <= 1'b0;
        end
        else
        begin
            state <= next_state;
            en_bypass <= next_en_bypass;
            en_pll <= next_en_pll;
            sync_cnt <= next_sync_cnt;
            byp_prev <= byp_clk;
            pll_prev <= pll_clk;
            o_system_clock <= next_system_clock;
            o_pll_mode_active <= next_en_pll;
        end
    end

    // Strap capture after reset release
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            strap <= 1'b0;
            strap_caught <= 1'b0;
            o_strap_state_bit <= 1'b0;
        end
        else if (!strap_caught)
        begin
            strap <= i_source_strap_pin;
            strap_caught <= 1'b1;
            o_strap_state_bit <= i_source_strap_pin;
        end
    end

    // Power control and fixed lock wait
    wire logic lock_reached = (lock_cnt >= 32'(LOCK_CYCLES));

    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            o_pll_power_down <= sys_clk_pkg::PLL_POWER_DOWN_RESET;
            o_pll_feedback_factor <= '0;
            lock_cnt <= 32'h0;
            o_pll_lock_done <= 1'b0;
        end
        else
        begin
            o_pll_power_down <= i_pll_power_down;
            o_pll_feedback_factor <= i_pll_feedback_factor;
            if (o_pll_power_down)
                lock_cnt <= 32'h0;
            else if (!lock_reached)
                lock_cnt <= lock_cnt + 32'h1;
            o_pll_lock_done <= ~o_pll_power_down & lock_reached;
        end
    end

    assign o_pll_input_clock = refdiv_link.out;

    // Probe source register on the I/O word port
    wire logic probe_hit = (i_io_addr == sys_clk_pkg::PROBE_SOURCE_ADDR);
    wire logic [sys_clk_pkg::IO_DATA_W-1:0] probe_read =
        {{(sys_clk_pkg::IO_DATA_W-sys_clk_pkg::PROBE_SOURCE_W){1'b0}}, probe_source_field};
    wire logic [sys_clk_pkg::IO_DATA_W-1:0] next_io_rdata = (i_io_re && probe_hit) ? probe_read : '0;

    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            probe_source_field <= sys_clk_pkg::PROBE_SOURCE_RESET;
            o_io_rdata <= '0;
        end
        else
        begin
            if (i_io_we && probe_hit)
                probe_source_field <= i_io_wdata[sys_clk_pkg::PROBE_SOURCE_LSB +: sys_clk_pkg::PROBE_SOURCE_W];
            o_io_rdata <= next_io_rdata;
        end
    end

    // Debug probe source selection, no glitch suppression
    logic next_debug_clock;

    always_comb
    begin
        unique case (probe_source_field)
            sys_clk_pkg::PROBE_HIGH: next_debug_clock = 1'b1;
            sys_clk_pkg::PROBE_LOW_A, sys_clk_pkg::PROBE_LOW_B: next_debug_clock = 1'b0;
            sys_clk_pkg::PROBE_USB_A, sys_clk_pkg::PROBE_USB_B: next_debug_clock = i_usb_pll_clock;
            sys_clk_pkg::PROBE_SAR: next_debug_clock = i_sar_clock;
            sys_clk_pkg::PROBE_SYSTEM: next_debug_clock = o_system_clock;
            sys_clk_pkg::PROBE_RESERVED: next_debug_clock = 1'b0;
            default: next_debug_clock = i_pll_output_clock;
        endcase
    end

    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            o_debug_clock_pin <= 1'b0;
            o_debug_clock_oe_b <= sys_clk_pkg::PROBE_DRIVER_OFF_RESET;
        end
        else
        begin
            o_debug_clock_pin <= next_debug_clock;
            o_debug_clock_oe_b <= i_probe_driver_off;
        end
    end
endmodule : system_clock_generator

// file: dv/system_clock_generator_chk.sv
`timescale 1ns/10ps
module sys_clk_gen_chk #(
    parameter int LOCK_CYCLES = 20
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_b,
    // Inputs watched
    input wire logic i_pll_power_down,
    input wire logic i_probe_driver_off,
    input wire logic [15:0] i_io_addr,
    input wire logic [15:0] i_io_wdata,
    input wire logic i_io_we,
    input wire logic i_io_re,
    // Outputs watched
    input wire logic [15:0] o_io_rdata,
    input wire logic o_pll_power_down,
    input wire logic o_pll_lock_done,
    input wire logic o_pll_mode_active,
    input wire logic o_debug_clock_pin,
    input wire logic o_debug_clock_oe_b
);
    logic [31:0] up_cnt;
    wire logic wr_hit;
    assign wr_hit = i_io_we && (i_io_addr == sys_clk_pkg::PROBE_SOURCE_ADDR);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);
    // Cycles since the PLL was last powered up
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            up_cnt <= 32'h0;
        else if (o_pll_power_down)
            up_cnt <= 32'h0;
        else
            up_cnt <= up_cnt + 32'h1;
    end
    property p_pd;
        i_pll_power_down |=> o_pll_power_down;
    endproperty
    a_pd: assert property (p_pd) else $error("power down not passed on");
    property p_oe;
        i_probe_driver_off |=> o_debug_clock_oe_b;
    endproperty
    a_oe: assert property (p_oe) else $error("probe driver still on");
    property p_rd_idle;
        !i_io_re |=> o_io_rdata == 16'h0000;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data without read");
    property p_rd_hi;
        i_io_re |=> o_io_rdata[15:4] == 12'h000;
    endproperty
    a_rd_hi: assert property (p_rd_hi) else $error("upper read bits set");
    property p_refuse;
        o_pll_power_down && !o_pll_mode_active |=> !o_pll_mode_active;
    endproperty
    a_refuse: assert property (p_refuse) else $error("PLL mode while powered down");
    property p_hi;
        wr_hit && i_io_wdata[3:0] == 4'h1 ##1 !i_io_we |-> ##1 o_debug_clock_pin;
    endproperty
    a_hi: assert property (p_hi) else $error("probe pin not high");
    property p_lo;
        wr_hit && (i_io_wdata[3:0] == 4'h3 || i_io_wdata[3:0] == 4'h5) ##1 !i_io_we |-> ##1 !o_debug_clock_pin;
    endproperty
    a_lo: assert property (p_lo) else $error("probe pin not low");
    property p_lock;
        up_cnt < LOCK_CYCLES |-> !o_pll_lock_done;
    endproperty
    a_lock: assert property (p_lock) else $error("lock reported too early");
endmodule : sys_clk_gen_chk

bind system_clock_generator sys_clk_gen_chk #(.LOCK_CYCLES(LOCK_CYCLES)) u_chk (.i_clk, .i_rst_b,
    .i_pll_power_down, .i_probe_driver_off, .i_io_addr, .i_io_wdata, .i_io_we, .i_io_re, .o_io_rdata,
    .o_pll_power_down, .o_pll_lock_done, .o_pll_mode_active, .o_debug_clock_pin, .o_debug_clock_oe_b);

// file: dv/tb_top.sv
`timescale 1ns/10ps
module tb_top;
    typedef struct {
        logic p, ou, rs;
        logic [6:0] orat;
        logic [11:0] rrat, fac;
        int es, eh, ei;
    } row_s;
    logic i_clk = 1'b0, i_rst_b, i_source_strap_pin, i_pll_path_select, i_pll_power_down;
    logic i_refdiv_skip, i_outdiv_use, i_probe_driver_off, i_io_we, i_io_re;
    logic [11:0] i_refdiv_ratio, i_pll_feedback_factor, o_pll_feedback_factor;
    logic [6:0] i_outdiv_ratio;
    logic [15:0] i_io_addr, i_io_wdata, o_io_rdata, d;
    logic [7:0] src_cnt = 8'h00;
    logic o_pll_power_down, o_pll_input_clock, o_strap_state_bit, o_pll_lock_done, o_pll_mode_active;
    logic o_system_clock, o_debug_clock_pin, o_debug_clock_oe_b, mon = 1'b0, mq = 1'b0;
    wire logic i_pll_output_clock = src_cnt[1];
    wire logic i_usb_pll_clock = src_cnt[2];
    wire logic i_external_clock_pin = src_cnt[3];
    wire logic i_sar_clock = src_cnt[4];
    wire logic i_rtc_clock = src_cnt[5];
    int err_count = 0, compares = 0, r, h, rl = 0;
    row_s rows [5] = '{'{1'b0, 1'b0, 1'b1, 7'h00, 12'h000, 12'h001, 60, 480, 60},
        '{1'b1, 1'b0, 1'b0, 7'h00, 12'h000, 12'h002, 240, 480, 15},
        '{1'b1, 1'b1, 1'b0, 7'h02, 12'h001, 12'hFFF, 80, 320, 12},
        '{1'b1, 1'b1, 1'b1, 7'h00, 12'h000, 12'h000, 240, 480, 60},
        '{1'b0, 1'b1, 1'b0, 7'h7F, 12'h000, 12'h010, 60, 480, 15}};
    system_clock_generator #(.LOCK_CYCLES(20)) u_dut (.i_clk, .i_rst_b, .i_external_clock_pin, .i_rtc_clock,
        .i_pll_output_clock, .i_usb_pll_clock, .i_sar_clock, .i_source_strap_pin, .i_pll_path_select,
        .i_pll_power_down, .i_refdiv_skip, .i_refdiv_ratio, .i_pll_feedback_factor, .i_outdiv_use,
        .i_outdiv_ratio, .i_probe_driver_off, .i_io_addr, .i_io_wdata, .i_io_we, .i_io_re, .o_io_rdata,
        .o_pll_power_down, .o_pll_feedback_factor, .o_pll_input_clock, .o_strap_state_bit, .o_pll_lock_done,
        .o_pll_mode_active, .o_system_clock, .o_debug_clock_pin, .o_debug_clock_oe_b);
    always #2.5 i_clk = ~i_clk;
    always @(negedge i_clk) src_cnt <= src_cnt + 8'h01;
    task automatic chk(input logic ok, input string m);
        compares++;
        if (ok !== 1'b1)
        begin
            err_count++;
            $display("wrong value at %0t: %s", $time, m);
        end
    endtask : chk
    function automatic logic near(input int a, input int e, input int t);
        return a >= e - t && a <= e + t;
    endfunction : near
    function automatic int exp_r(input logic [3:0] c);
        case (c)
            4'h1, 4'h3, 4'h5, 4'hD: return 0;
            4'h7, 4'hF: return 8;
            4'h9: return 2;
            4'hB: return 4;
            default: return 16;
        endcase
    endfunction : exp_r
    // Rising edges and high cycles of one clock output over n cycles
    task automatic meas(input int sel, input int n, output int rc, output int hc);
        logic v;
        logic q;
        rc = 0;
        hc = 0;
        q = 1'b1;
        repeat (n)
        begin
            @(negedge i_clk);
            v = sel == 0 ? o_system_clock : (sel == 1 ? o_pll_input_clock : o_debug_clock_pin);
            if (v === 1'b1 && q === 1'b0) rc++;
            if (v === 1'b1) hc++;
            q = v;
        end
    endtask : meas
    task automatic wr(input logic [15:0] a, input logic [15:0] dw);
        i_io_addr = a;
        i_io_wdata = dw;
        i_io_we = 1'b1;
        @(negedge i_clk);
        i_io_we = 1'b0;
        @(negedge i_clk);
    endtask : wr
    task automatic rd(input logic [15:0] a, output logic [15:0] dr);
        i_io_addr = a;
        i_io_re = 1'b1;
        @(negedge i_clk);
        i_io_re = 1'b0;
        dr = o_io_rdata;
        @(negedge i_clk);
    endtask : rd
    task automatic end_of_test;
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : end_of_test
    // Flags any one-cycle pulse on the system clock while modes switch
    always @(negedge i_clk)
    begin
        if (mon && o_system_clock !== mq)
        begin
            chk(rl >= 2, "short clock pulse");
            rl = 0;
        end
        rl++;
        mq = o_system_clock;
    end
    initial
    begin
        #150000;
        err_count++;
        end_of_test();
    end
    initial
    begin
        {i_rst_b, i_pll_path_select, i_refdiv_skip, i_outdiv_use, i_probe_driver_off, i_io_we, i_io_re} = 7'h00;
        {i_source_strap_pin, i_pll_power_down} = 2'b11;
        {i_refdiv_ratio, i_pll_feedback_factor, i_outdiv_ratio, i_io_addr, i_io_wdata} = '0;
        repeat (3) @(negedge i_clk);
        chk(o_pll_power_down === 1'b1, "power down in reset");
        i_rst_b = 1'b1;
        @(negedge i_clk);
        rd(16'h1C24, d);
        chk(d === 16'h000B, "probe reset value");
        chk(o_strap_state_bit === 1'b1 && o_debug_clock_oe_b === 1'b0, "strap or driver");
        i_pll_path_select = 1'b1;
        repeat (60) @(negedge i_clk);
        chk(o_pll_mode_active === 1'b0, "PLL taken while down");
        i_pll_path_select = 1'b0;
        i_pll_power_down = 1'b0;
        repeat (2) @(negedge i_clk);
        chk(o_pll_power_down === 1'b0 && o_pll_lock_done === 1'b0, "power up");
        for (int i = 0; i < 100 && o_pll_lock_done !== 1'b1; i++) @(negedge i_clk);
        chk(o_pll_lock_done === 1'b1, "no lock");
        $display("test reset and lock done");
        mon = 1'b1;
        foreach (rows[k])
        begin
            i_pll_path_select = 1'b0;
            repeat (60) @(negedge i_clk);
            {i_outdiv_use, i_outdiv_ratio, i_refdiv_skip} = {rows[k].ou, rows[k].orat, rows[k].rs};
            {i_refdiv_ratio, i_pll_feedback_factor} = {rows[k].rrat, rows[k].fac};
            repeat (30) @(negedge i_clk);
            i_pll_path_select = rows[k].p;
            repeat (100) @(negedge i_clk);
            chk(o_pll_mode_active === rows[k].p && o_pll_feedback_factor === rows[k].fac, "mode");
            meas(0, 960, r, h);
            chk(near(r, rows[k].es, 2), "system clock rate");
            chk(near(h, rows[k].eh, 30), "system clock duty");
            meas(1, 960, r, h);
            chk(near(r, rows[k].ei, 1), "PLL input rate");
        end
        mon = 1'b0;
        $display("test mode rows done");
        for (int c = 0; c < 16; c++)
        begin
            wr(16'h1C24, {12'hABC, 4'(c)});
            rd(16'h1C24, d);
            chk(d === {12'h000, 4'(c)}, "probe readback");
            meas(2, 64, r, h);
            chk(near(r, exp_r(4'(c)), 1), "probe source");
            chk(c != 1 || h == 64, "probe high");
            chk(!(c inside {3, 5, 13}) || h == 0, "probe low");
        end
        wr(16'h1C25, 16'h0001);
        rd(16'h1C24, d);
        chk(d === 16'h000F, "stray write taken");
        rd(16'h1C26, d);
        chk(d === 16'h0000, "unmapped read");
        i_probe_driver_off = 1'b1;
        repeat (2) @(negedge i_clk);
        chk(o_debug_clock_oe_b === 1'b1, "driver still on");
        $display("test probe done");
        i_pll_power_down = 1'b1;
        i_rst_b = 1'b0;
        i_source_strap_pin = 1'b0;
        repeat (3) @(negedge i_clk);
        chk(o_debug_clock_oe_b === 1'b0 && o_pll_mode_active === 1'b0, "reset values");
        i_rst_b = 1'b1;
        repeat (2) @(negedge i_clk);
        chk(o_strap_state_bit === 1'b0 && o_pll_power_down === 1'b1, "strap after reset");
        meas(0, 960, r, h);
        chk(near(r, 15, 2), "bypass from RTC");
        $display("test strap done");
        end_of_test();
    end
endmodule : tb_top
